// >>> hw/fsps_consts.svh
// Constants for the flash self-programming sequencer
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH
`define FSPS_ADDR_CTRL     2'h0
`define FSPS_ADDR_LOCKS    2'h1
`define FSPS_ADDR_STATUS   2'h2
`define FSPS_ADDR_EEPROM   2'h3
`define FSPS_CMD_MASK      8'h1f
`define FSPS_CMD_LOAD      8'h01
`define FSPS_CMD_ERASE     8'h03
`define FSPS_CMD_WRITE     8'h05
`define FSPS_CMD_LOCK      8'h09
`define FSPS_CMD_REEN      8'h11
`define FSPS_BIT_IE        7
`define FSPS_BIT_BUSY      6
`define FSPS_STORE_WIN     3'h4
`define FSPS_LOAD_WIN      3'h3
`define FSPS_PTR_LOCK      16'h0001
`define FSPS_PTR_FLOW      16'h0000
`define FSPS_PTR_EFUSE     16'h0002
`define FSPS_PTR_FHIGH     16'h0003
`define FSPS_LOCK_LO       2
`define FSPS_LOCK_MASK     8'h3c
`define FSPS_EFUSE_MASK    8'h0f
`define FSPS_ALL_ONES      8'hff
`define FSPS_PROG_NS       4500000
`endif

// >>> hw/fsps_pkg.sv
// Types for the flash self-programming sequencer
package fsps_pkg;
	typedef enum logic [2:0] {
		FSPS_IDLE  = 3'b000,
		FSPS_ARMED = 3'b001,
		FSPS_PROG  = 3'b010
	} fsps_state_t;
	typedef struct packed {
		logic        store;
		logic        load;
		logic [15:0] ptr;
		logic [15:0] data;
	} fsps_cpu_req_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} fsps_read_t;
endpackage

// >>> hw/fsps_seq.sv
// Flash self-programming sequencer top
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "fsps_consts.svh"
// Function
// - Erase pattern plus store within four cycles erases addressed page, data ignored.
// - Erase ignores pointer bits outside the page address field.
// - Erase of concurrent section keeps other readable; other section halts CPU.
// - Load pattern plus store within four cycles writes data pair to buffer.
// - Word-in-page field picks buffer location; any order allowed.
// - Buffer cleared after page write, on re-enable, and on reset.
// - EEPROM write starting during page loading discards buffer contents.
// - Write pattern plus store within four cycles programs buffer into page.
// - Write to concurrent section keeps other readable; other section halts CPU.
// - Ready interrupt asserted while enabled and enable bit is clear.
// - Erase or write blocks concurrent section reads and holds busy flag.
// - Lock pattern plus store programs lock bits where data bits 5..2 zero.
// - Lock programming blocks no flash section.
// - EEPROM write blocks self-programming and fuse or lock reads.
// - Armed lock mode with pointer 0x0001 load returns lock bits.
// - Lock arm clears on read or no store in four; loads are only taken in the first three.
// - Armed read with pointer 0x0000 returns fuse low byte.
// - Pointer 0x0003 returns fuse high, 0x0002 extended fuse low nibble.
// - Programmed bits read 0, unprogrammed bits read 1.
// - Only five valid low command patterns change command state.
// - Enable bit stays set through erase or write, then clears.
module fsps_seq #(
	parameter int PAGE_W    = 6,
	parameter int WORD_W    = 5,
	parameter int LOW_PAGES = 48,
	parameter int PROG_CYC  = (`FSPS_PROG_NS + 9) / 10,
	parameter logic [7:0] FUSE_LOW  = 8'hff,
	parameter logic [7:0] FUSE_HIGH = 8'hff,
	parameter logic [7:0] FUSE_EXT  = 8'hff
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic [1:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	input  wire fsps_pkg::fsps_cpu_req_t cpu_req,
	output fsps_pkg::fsps_read_t       cpu_rd,
	input  wire logic                  eeprom_write_pending,
	output logic                       cpu_halt,
	output logic                       rw_section_busy_flag,
	output logic                       spm_ready_irq,
	output logic                       flash_prog_req,
	output logic                       flash_erase_req,
	output logic [PAGE_W-1:0]          flash_page,
	output logic [15:0]                flash_wdata,
	output logic [WORD_W-1:0]          flash_waddr
);
	import fsps_pkg::*;

	localparam int DEPTH = 1 << WORD_W;
	localparam int CW    = $clog2(PROG_CYC + 1);

	fsps_state_t         state_r;
	logic [4:0]          cmd_r;
	logic                irq_en_r;
	logic [2:0]          win_r;
	logic [CW-1:0]       cnt_r;
	logic [PAGE_W-1:0]   page_r;
	logic                page_halt_r;
	logic                erasing_r;
	logic [15:0]         buf_mem [DEPTH];
	logic [DEPTH-1:0]    buf_vld_r;
	logic                loading_r;
	logic                ee_d_r;
	logic [7:0]          lock_bits_r;
	logic                busy_r;
	logic [7:0]          rdata_r;
	logic                rd_valid_r;
	logic [7:0]          rd_data_r;
	logic [2:0]          rd_win_r;
	logic                halt_r;
	logic                irq_r;
	logic                pr_r;
	logic                er_r;
	logic [WORD_W-1:0]   wa_r;
	logic [15:0]         wd_r;

	logic                ctrl_wr;
	logic [4:0]          cmd_nxt;
	logic                cmd_ok;
	logic                store_ok;
	logic                load_ok;
	logic                prog_done;
	logic                ee_start;
	logic [WORD_W-1:0]   wa_nxt;

	// Page field of a pointer, word address ignores the byte bit
	function automatic logic [PAGE_W-1:0] page_of(input logic [15:0] p);
		page_of = p[WORD_W+PAGE_W:WORD_W+1];
	endfunction

	function automatic logic [WORD_W-1:0] word_of(input logic [15:0] p);
		word_of = p[WORD_W:1];
	endfunction

	// Command decode; a pending EEPROM write locks out new commands
	assign ctrl_wr  = reg_wr && reg_addr == `FSPS_ADDR_CTRL;
	assign cmd_nxt  = reg_wdata[4:0];
	assign cmd_ok   = ({3'h0, cmd_nxt} == `FSPS_CMD_LOAD) ||
	                  ({3'h0, cmd_nxt} == `FSPS_CMD_ERASE) ||
	                  ({3'h0, cmd_nxt} == `FSPS_CMD_WRITE) ||
	                  ({3'h0, cmd_nxt} == `FSPS_CMD_LOCK) ||
	                  ({3'h0, cmd_nxt} == `FSPS_CMD_REEN);
	assign store_ok = state_r == FSPS_ARMED && cpu_req.store && win_r != 3'h0 &&
	                  !eeprom_write_pending;
	assign load_ok  = state_r == FSPS_ARMED && cpu_req.load && rd_win_r != 3'h0 &&
	                  {3'h0, cmd_r} == `FSPS_CMD_LOCK;
	assign prog_done = state_r == FSPS_PROG && cnt_r == CW'(1);
	assign ee_start = eeprom_write_pending && !ee_d_r;
	assign wa_nxt   = wa_r + WORD_W'(1);                      // Scan address of the next cycle

	// Sequencer state, windows and duration counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r   <= FSPS_IDLE;
			cmd_r     <= 5'h00;
			win_r     <= 3'h0;
			rd_win_r  <= 3'h0;
			cnt_r     <= '0;
			erasing_r <= 1'b0;
		end else begin
			case (state_r)
				FSPS_IDLE: begin
					if (ctrl_wr && cmd_ok && !eeprom_write_pending) begin
						state_r  <= FSPS_ARMED;
						cmd_r    <= cmd_nxt;
						win_r    <= `FSPS_STORE_WIN;
						rd_win_r <= `FSPS_LOAD_WIN;
					end
				end
				FSPS_ARMED: begin
					win_r    <= win_r - 3'h1;
					rd_win_r <= (rd_win_r != 3'h0) ? rd_win_r - 3'h1 : 3'h0;
					if (store_ok && ({3'h0, cmd_r} == `FSPS_CMD_ERASE ||
					    {3'h0, cmd_r} == `FSPS_CMD_WRITE)) begin
						state_r   <= FSPS_PROG;
						cnt_r     <= CW'(PROG_CYC);
						erasing_r <= {3'h0, cmd_r} == `FSPS_CMD_ERASE;
					end else if (store_ok || load_ok || win_r == 3'h1) begin
						state_r <= FSPS_IDLE;
						cmd_r   <= 5'h00;
					end
				end
				FSPS_PROG: begin
					cnt_r <= cnt_r - CW'(1);
					if (prog_done) begin
						state_r <= FSPS_IDLE;
						cmd_r   <= 5'h00;
					end
				end
				default: begin
					state_r <= FSPS_IDLE;
					cmd_r   <= 5'h00;
				end
			endcase
		end
	end

	// Page address latched at the start of erase or write
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			page_r      <= '0;
			page_halt_r <= 1'b0;
		end else if (store_ok && ({3'h0, cmd_r} == `FSPS_CMD_ERASE ||
		             {3'h0, cmd_r} == `FSPS_CMD_WRITE)) begin
			page_r      <= page_of(cpu_req.ptr);
			page_halt_r <= 32'(page_of(cpu_req.ptr)) >= LOW_PAGES;
		end
	end

	// Temporary buffer contents; valid bits model the erased state cheaply
	always_ff @(posedge clk_sys) begin
		if (store_ok && {3'h0, cmd_r} == `FSPS_CMD_LOAD) begin
			buf_mem[word_of(cpu_req.ptr)] <= cpu_req.data;
		end
	end

	// Buffer valid map and loading status
	always_ff @(posedge clk_sys) begin
		ee_d_r <= rst_n && eeprom_write_pending;
		if (!rst_n) begin
			buf_vld_r <= '0;
			loading_r <= 1'b0;
		end else if ((prog_done && !erasing_r) || (ee_start && loading_r) ||
		             (store_ok && {3'h0, cmd_r} == `FSPS_CMD_REEN)) begin
			buf_vld_r <= '0;
			loading_r <= 1'b0;
		end else if (store_ok && {3'h0, cmd_r} == `FSPS_CMD_LOAD) begin
			buf_vld_r[word_of(cpu_req.ptr)] <= 1'b1;
			loading_r <= 1'b1;
		end
	end

	// Lock bits: programming only clears, never sets back
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lock_bits_r <= `FSPS_ALL_ONES;
		end else if (store_ok && {3'h0, cmd_r} == `FSPS_CMD_LOCK) begin
			lock_bits_r <= lock_bits_r & (cpu_req.data[7:0] | ~`FSPS_LOCK_MASK);
		end
	end

	// Section busy: set by erase or write, cleared by re-enable or a load
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
		end else if (store_ok && ({3'h0, cmd_r} == `FSPS_CMD_ERASE ||
		             {3'h0, cmd_r} == `FSPS_CMD_WRITE)) begin
			busy_r <= 1'b1;
		end else if (store_ok && ({3'h0, cmd_r} == `FSPS_CMD_REEN ||
		             {3'h0, cmd_r} == `FSPS_CMD_LOAD)) begin
			busy_r <= 1'b0;
		end
	end

	// Armed fuse and lock reads
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_valid_r <= 1'b0;
			rd_data_r  <= 8'h00;
		end else begin
			rd_valid_r <= load_ok && !eeprom_write_pending;
			case (cpu_req.ptr)
				`FSPS_PTR_LOCK:  rd_data_r <= lock_bits_r;
				`FSPS_PTR_FLOW:  rd_data_r <= FUSE_LOW;
				`FSPS_PTR_FHIGH: rd_data_r <= FUSE_HIGH;
				`FSPS_PTR_EFUSE: rd_data_r <= FUSE_EXT & `FSPS_EFUSE_MASK;
				default:         rd_data_r <= `FSPS_ALL_ONES;
			endcase
		end
	end

	// Flash array side, halt and interrupt outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			halt_r <= 1'b0;
			irq_r  <= 1'b0;
			pr_r   <= 1'b0;
			er_r   <= 1'b0;
			wa_r   <= '0;
			wd_r   <= 16'h0000;
		end else begin
			halt_r <= state_r == FSPS_PROG && !prog_done && page_halt_r;
			irq_r  <= irq_en_r && state_r != FSPS_ARMED && !(state_r == FSPS_PROG && !prog_done);
			pr_r   <= prog_done && !erasing_r;
			er_r   <= prog_done && erasing_r;
			wa_r   <= wa_nxt;
			wd_r   <= buf_vld_r[wa_nxt] ? buf_mem[wa_nxt] : 16'hffff; // Word stands with its address
		end
	end

	// Register reads; enable bit reflects armed or programming state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_en_r <= 1'b0;
			rdata_r  <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				irq_en_r <= reg_wdata[`FSPS_BIT_IE];
			end
			if (reg_rd) begin
				case (reg_addr)
					`FSPS_ADDR_CTRL:   rdata_r <= {irq_en_r, busy_r, 1'b0,
					                    (state_r != FSPS_IDLE) ? cmd_r : 5'h00};
					`FSPS_ADDR_LOCKS:  rdata_r <= lock_bits_r;
					`FSPS_ADDR_STATUS: rdata_r <= {6'h00, loading_r, erasing_r};
					default:           rdata_r <= {7'h00, eeprom_write_pending};
				endcase
			end else begin
				rdata_r <= 8'h00;
			end
		end
	end

	assign reg_rdata            = rdata_r;
	assign cpu_rd               = '{valid: rd_valid_r, data: rd_data_r};
	assign cpu_halt             = halt_r;
	assign rw_section_busy_flag = busy_r;
	assign spm_ready_irq        = irq_r;
	assign flash_prog_req       = pr_r;
	assign flash_erase_req      = er_r;
	assign flash_page           = page_r;
	assign flash_wdata          = wd_r;
	assign flash_waddr          = wa_r;

	// Checks
	property p_store_win;
		@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_wr && cmd_ok && state_r == FSPS_IDLE && !eeprom_write_pending) ##1
		(!cpu_req.store && !cpu_req.load) [*4] |=> state_r == FSPS_IDLE;
	endproperty
	a_store_win: assert property (p_store_win) else $error("arm did not time out");
	property p_busy_set;
		@(posedge clk_sys) disable iff (!rst_n)
		(store_ok && {3'h0, cmd_r} == `FSPS_CMD_ERASE) |=> busy_r && state_r == FSPS_PROG;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set");
	property p_done;
		@(posedge clk_sys) disable iff (!rst_n)
		prog_done |=> state_r == FSPS_IDLE && (flash_prog_req || flash_erase_req);
	endproperty
	a_done: assert property (p_done) else $error("programming end wrong");
	property p_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(prog_done && !erasing_r) |=> buf_vld_r == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("buffer not cleared");
	property p_ee;
		@(posedge clk_sys) disable iff (!rst_n)
		eeprom_write_pending && state_r == FSPS_IDLE |=> state_r == FSPS_IDLE;
	endproperty
	a_ee: assert property (p_ee) else $error("armed during eeprom write");
	property p_irq;
		@(posedge clk_sys) disable iff (!rst_n)
		(irq_en_r && state_r == FSPS_IDLE) ##1 (state_r == FSPS_IDLE) |-> spm_ready_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("ready irq missing");
	property p_lockrd;
		@(posedge clk_sys) disable iff (!rst_n)
		(load_ok && !eeprom_write_pending && cpu_req.ptr == `FSPS_PTR_LOCK) |=>
		cpu_rd.valid && cpu_rd.data == $past(lock_bits_r);
	endproperty
	a_lockrd: assert property (p_lockrd) else $error("lock read wrong");
	property p_bad;
		@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_wr && !cmd_ok && state_r == FSPS_IDLE) |=> state_r == FSPS_IDLE;
	endproperty
	a_bad: assert property (p_bad) else $error("bad pattern armed");
	// Halt follows the latched page; lock set and EEPROM refusals leave flash alone
	property p_halt_low;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_r == FSPS_PROG && !page_halt_r) |=> !cpu_halt;
	endproperty
	a_halt_low: assert property (p_halt_low) else $error("halt on concurrent page");
	property p_halt_high;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_r == FSPS_PROG && !prog_done && page_halt_r) |=> cpu_halt;
	endproperty
	a_halt_high: assert property (p_halt_high) else $error("page not halted");
	property p_ee_store;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_r == FSPS_ARMED && cpu_req.store && eeprom_write_pending) |=>
		state_r != FSPS_PROG && lock_bits_r == $past(lock_bits_r);
	endproperty
	a_ee_store: assert property (p_ee_store) else $error("store during eeprom write");
	property p_reen_clr;
		@(posedge clk_sys) disable iff (!rst_n)
		(store_ok && {3'h0, cmd_r} == `FSPS_CMD_REEN) |=>
		!rw_section_busy_flag && buf_vld_r == '0;
	endproperty
	a_reen_clr: assert property (p_reen_clr) else $error("re-enable left busy or data");
	property p_lock_keep;
		@(posedge clk_sys) disable iff (!rst_n)
		(store_ok && {3'h0, cmd_r} == `FSPS_CMD_LOCK) |=>
		state_r == FSPS_IDLE && !cpu_halt && rw_section_busy_flag == $past(rw_section_busy_flag);
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock set blocked flash");
	property p_ee_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(ee_start && loading_r) |=> buf_vld_r == '0 && !loading_r;
	endproperty
	a_ee_clear: assert property (p_ee_clear) else $error("eeprom start kept buffer");
	c_erase: cover property (@(posedge clk_sys) disable iff (!rst_n) prog_done && erasing_r);
	c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) prog_done && !erasing_r);
	c_read:  cover property (@(posedge clk_sys) disable iff (!rst_n) cpu_rd.valid);
	c_lock:  cover property (@(posedge clk_sys) disable iff (!rst_n)
	                         store_ok && {3'h0, cmd_r} == `FSPS_CMD_LOCK);
	c_ee:    cover property (@(posedge clk_sys) disable iff (!rst_n)
	                         ee_start && loading_r);
endmodule

// >>> tb/fsps_cpu_model.sv
// CPU-side model that issues store and load requests to the sequencer
`timescale 1ns/10ps
module fsps_cpu_model (
	input  wire logic                    clk_sys,
	output fsps_pkg::fsps_cpu_req_t      cpu_req,
	input  wire fsps_pkg::fsps_read_t    cpu_rd
);
	import fsps_pkg::*;

	// Idle request with no strobes
	initial begin
		cpu_req = '0;
	end

	// One store pulse; pointer and data are inverted afterwards so a missed latch shows up
	task automatic do_store(input logic [15:0] ptr, input logic [15:0] data);
		@(posedge clk_sys);
		cpu_req.ptr   <= ptr;
		cpu_req.data  <= data;
		cpu_req.store <= 1'b1;
		@(posedge clk_sys);
		cpu_req.store <= 1'b0;
		cpu_req.ptr   <= ~ptr;
		cpu_req.data  <= ~data;
	endtask

	// One load pulse; the answer is taken in the cycle after the accepting edge
	task automatic do_load(input logic [15:0] ptr, output fsps_read_t rd);
		@(posedge clk_sys);
		cpu_req.ptr  <= ptr;
		cpu_req.load <= 1'b1;
		@(posedge clk_sys);
		cpu_req.load <= 1'b0;
		cpu_req.ptr  <= ~ptr;
		#1;
		rd = cpu_rd;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
`include "fsps_consts.svh"
module testbench;
	import fsps_pkg::*;
	localparam int PROG_CYC = 8;
	logic           clk_sys              = 1'b0;
	logic           rst_n                = 1'b0;
	logic [1:0]     reg_addr             = 2'h0;
	logic [7:0]     reg_wdata            = 8'h00;
	logic           reg_wr               = 1'b0;
	logic           reg_rd               = 1'b0;
	logic           eeprom_write_pending = 1'b0;
	logic [7:0]     reg_rdata;
	fsps_cpu_req_t  cpu_req;
	fsps_read_t     cpu_rd;
	fsps_read_t     rd;
	logic           cpu_halt;
	logic           rw_section_busy_flag;
	logic           spm_ready_irq;
	logic           flash_prog_req;
	logic           flash_erase_req;
	logic [5:0]     flash_page;
	logic [15:0]    flash_wdata;
	logic [4:0]     flash_waddr;
	logic [7:0]     v;
	logic [7:0]     exp_rd [4] = '{8'ha5, 8'hff, 8'h06, 8'h3c};
	int             num_errors = 0;
	int             checks     = 0;
	int             cycles     = 0;

	fsps_seq #(.PROG_CYC(PROG_CYC), .FUSE_LOW(8'ha5), .FUSE_HIGH(8'h3c), .FUSE_EXT(8'hf6))
	fsps_seq_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_req(cpu_req), .cpu_rd(cpu_rd), .eeprom_write_pending(eeprom_write_pending),
		.cpu_halt(cpu_halt), .rw_section_busy_flag(rw_section_busy_flag),
		.spm_ready_irq(spm_ready_irq), .flash_prog_req(flash_prog_req),
		.flash_erase_req(flash_erase_req), .flash_page(flash_page),
		.flash_wdata(flash_wdata), .flash_waddr(flash_waddr));

	fsps_cpu_model fsps_cpu_model_inst (.clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_rd(cpu_rd));

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Wait until the buffer scan shows word a; a missing scan ends at the hang guard
	task automatic wait_word(input logic [4:0] a);
		@(posedge clk_sys);
		#1;
		while (flash_waddr != a) begin
			@(posedge clk_sys);
			#1;
		end
	endtask

	// Arm, store, watch the run and its single completion pulse
	task automatic run_prog(input logic [7:0] cmd, input logic [15:0] ptr,
		input logic [5:0] page, input logic halt);
		reg_write(`FSPS_ADDR_CTRL, 8'h80 | cmd);
		fsps_cpu_model_inst.do_store(ptr, 16'ha5a5);
		repeat (2) @(posedge clk_sys);
		#1;
		check(cpu_halt, halt);
		if (!halt) check(rw_section_busy_flag, 1'b1);
		check(spm_ready_irq, 1'b0);
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v & 8'hbf, 8'h80 | cmd);
		for (int i = 0; i < 3 * PROG_CYC && !(flash_prog_req || flash_erase_req); i++) begin
			@(posedge clk_sys);
			#1;
		end
		check({flash_prog_req, flash_erase_req}, {cmd == 8'h05, cmd == 8'h03});
		check(flash_page, page);
		repeat (2) @(posedge clk_sys);
		#1;
		check({cpu_halt, spm_ready_irq}, 2'b01);
	endtask

	task automatic give_verdict();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v, 8'h00);
		reg_read(`FSPS_ADDR_LOCKS, v);
		check(v, 8'hff);
		$display("test reset values done");
		// Armed reads of all four pointers; each read drops the arm
		for (int i = 0; i < 4; i++) begin
			reg_write(`FSPS_ADDR_CTRL, `FSPS_CMD_LOCK);
			fsps_cpu_model_inst.do_load(16'(i), rd);
			check(rd.valid, 1'b1);
			check(rd.data & (i == 2 ? 8'h0f : 8'hff), exp_rd[i]);
			reg_read(`FSPS_ADDR_CTRL, v);
			check(v, 8'h00);
		end
		// A load after the three-cycle window is plain flash access
		reg_write(`FSPS_ADDR_CTRL, `FSPS_CMD_LOCK);
		repeat (2) @(posedge clk_sys);
		fsps_cpu_model_inst.do_load(16'h0001, rd);
		check(rd.valid, 1'b0);
		// A store after the four-cycle window starts nothing
		reg_write(`FSPS_ADDR_CTRL, `FSPS_CMD_ERASE);
		repeat (3) @(posedge clk_sys);
		fsps_cpu_model_inst.do_store(16'h0080, 16'h0000);
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v, 8'h00);
		$display("test armed reads and windows done");
		// Patterns outside the five legal ones leave the command state alone
		foreach (exp_rd[i]) begin
			reg_write(`FSPS_ADDR_CTRL, 8'h07 + 8'(i * 6));
			reg_read(`FSPS_ADDR_CTRL, v);
			check(v, 8'h00);
		end
		reg_write(`FSPS_ADDR_CTRL, 8'h87);
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v, 8'h80);
		check(spm_ready_irq, 1'b1);
		// Pending EEPROM write refuses an armed store and a new arming
		reg_write(`FSPS_ADDR_CTRL, 8'h89);
		@(posedge clk_sys);
		eeprom_write_pending <= 1'b1;
		fsps_cpu_model_inst.do_store(16'h0001, 16'h0000);
		reg_write(`FSPS_ADDR_CTRL, 8'h89);
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v, 8'h80);
		reg_read(`FSPS_ADDR_LOCKS, v);
		check(v, 8'hff);
		@(posedge clk_sys);
		eeprom_write_pending <= 1'b0;
		$display("test refused commands done");
		// Load one word, then an EEPROM write start throws the buffer away
		reg_write(`FSPS_ADDR_CTRL, 8'h81);
		fsps_cpu_model_inst.do_store(16'h0006, 16'h1234);
		reg_read(2'h2, v);
		check(v, 8'h02);
		@(posedge clk_sys);
		eeprom_write_pending <= 1'b1;
		@(posedge clk_sys);
		eeprom_write_pending <= 1'b0;
		reg_read(2'h2, v);
		check(v, 8'h00);
		wait_word(5'h03);
		check(flash_wdata, 16'hffff);
		$display("test page load done");
		// Page write into the concurrent section, then re-enable it
		reg_write(`FSPS_ADDR_CTRL, 8'h81);
		fsps_cpu_model_inst.do_store(16'h0002, 16'hbeef);
		wait_word(5'h01);
		check(flash_wdata, 16'hbeef);
		run_prog(`FSPS_CMD_WRITE, 16'h0040, 6'h01, 1'b0);
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v, 8'hc0);
		wait_word(5'h01);
		check(flash_wdata, 16'hffff);
		reg_write(`FSPS_ADDR_CTRL, 8'h81);
		fsps_cpu_model_inst.do_store(16'h0004, 16'h1111);
		reg_write(`FSPS_ADDR_CTRL, 8'h91);
		fsps_cpu_model_inst.do_store(16'h0000, 16'h0000);
		reg_read(`FSPS_ADDR_CTRL, v);
		check(v, 8'h80);
		check(rw_section_busy_flag, 1'b0);
		reg_read(2'h2, v);
		check(v, 8'h00);
		wait_word(5'h02);
		check(flash_wdata, 16'hffff);
		$display("test page write done");
		// Erase of a halting page with stray pointer bits set
		run_prog(`FSPS_CMD_ERASE, 16'hfcbf, 6'h32, 1'b1);
		reg_write(`FSPS_ADDR_CTRL, 8'h91);
		fsps_cpu_model_inst.do_store(16'h0000, 16'h0000);
		#1;
		check(rw_section_busy_flag, 1'b0);
		$display("test page erase done");
		// A mid-run reset empties the buffer
		reg_write(`FSPS_ADDR_CTRL, 8'h01);
		fsps_cpu_model_inst.do_store(16'h000a, 16'h5555);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_word(5'h05);
		check(flash_wdata, 16'hffff);
		reg_read(2'h2, v);
		check(v, 8'h00);
		$display("test reset clear done");
		// Lock set: bits 5..2 cleared in the data are programmed
		reg_write(`FSPS_ADDR_CTRL, `FSPS_CMD_LOCK);
		fsps_cpu_model_inst.do_store(16'h0001, 16'h00c3);
		#1;
		check({cpu_halt, rw_section_busy_flag}, 2'b00);
		repeat (2 * PROG_CYC) @(posedge clk_sys);
		reg_read(`FSPS_ADDR_LOCKS, v);
		check(v, 8'hc3);
		$display("test lock set done");
		give_verdict();
	end
endmodule
